/* File: shared/hpspc_pkg.sv */
// How it works
// - Main outputs drop while main supply is under lockout; aux runs from standby.
// - Aux output follows aux pin or control bit, independent of mains.
// - Main undervoltage trips the slot's mains, aux untouched, only while mains are enabled.
// - Slow overcurrent past fault timer trips the slot's mains, aux untouched.
// - Fast overcurrent comparator shuts the slot's mains at once.
// - Aux breaker trips only after fault timer expires in current limit.
// - Host clears a trip by cycling control bits one and zero.
// - Fault output asserts on current or undervoltage trips only for pin-enabled outputs; overtemperature trips assert it too.
// - Attention asserts with any trip unless masked.
// - Attention holds until host writes one to each set fault bit.
// - Slot overtemperature shuts that slot's main and aux outputs and asserts slot fault.
// - Die overtemperature shuts both slots and sets the die overheat bit.
// - Power good asserts when slot enabled and main and aux deliver power.
// - Override turns on the slot's main and aux outputs unless die is hot, and defeats current and slot thermal protection.
// - Override also defeats main undervoltage lockouts but never standby lockout.
// - Override releases the slot's power good and fault outputs.
// - Control bit two blocks the slot's override input.
// - General inputs read as bits four and five of common flags.
// - Only read byte and write byte; alert response address never answered.
// - Bus address is fixed upper bits plus three straps sampled after power-up.
// - Mask bit three of common flags inhibits attention output.
package hpspc_pkg;
    // Register command codes
    localparam logic [7:0] REG_CTRL_A = 8'h02;
    localparam logic [7:0] REG_CTRL_B = 8'h03;
    localparam logic [7:0] REG_STAT_A = 8'h04;
    localparam logic [7:0] REG_STAT_B = 8'h05;
    localparam logic [7:0] REG_FLAGS = 8'h06;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // Control register fields
    localparam int CTRL_AUX_BIT = 0;
    localparam int CTRL_MAIN_BIT = 1;
    localparam int CTRL_OVR_BLOCK_BIT = 2;
    // Slot status fields
    localparam int STAT_MAIN_OC_BIT = 0;
    localparam int STAT_MAIN_UV_BIT = 2;
    localparam int STAT_AUX_BIT = 4;
    localparam int STAT_FAULT_PIN_BIT = 7;
    // Common flags fields
    localparam int FLAGS_SLOT_HOT_BIT = 1;
    localparam int FLAGS_DIE_HOT_BIT = 2;
    localparam int FLAGS_MASK_BIT = 3;
    localparam int FLAGS_GPI_A_BIT = 4;
    localparam int FLAGS_GPI_B_BIT = 5;
    // Bus address upper bits
    localparam logic [3:0] BUS_ADDR_HIGH = 4'h8;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_DELAY_US = 250;
    localparam int POR_CYCLES = POR_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int FAULT_TIMER_US = 20;
    localparam int FAULT_TIMER_CYCLES = FAULT_TIMER_US * 1000 / CLK_PERIOD_NS;
    localparam int TMR_W = 16;
    localparam int POR_W = 16;
    // Bus slave states
    typedef enum logic [2:0] {
        HPS_IDLE = 3'b000,
        HPS_ADDR = 3'b001,
        HPS_CMD = 3'b010,
        HPS_WDATA = 3'b011,
        HPS_ACK = 3'b100,
        HPS_RDATA = 3'b101,
        HPS_RACK = 3'b110
    } hps_state_e;
endpackage

/* File: design/hpspc_smbus.sv */
`timescale 1ns/1ps
module hpspc_smbus
    import hpspc_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic enable, // Bus live after power-on delay
    input wire logic [6:0] dev_addr, // Own 7-bit address
    input wire logic scl, // Bus clock level
    input wire logic sda_in, // Bus data level
    output logic sda_oe_n, // Low pulls data line low
    output logic wr_stb, // One-cycle register write
    output logic [7:0] ptr, // Register pointer
    output logic [7:0] wr_data, // Write data
    input wire logic [7:0] rd_data // Read data at pointer
);
    hps_state_e state;
    hps_state_e after_ack;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    // Edge and condition detection
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    assign start_c = scl & scl_q & sda_q & ~sda_in;
    assign stop_c = scl & scl_q & ~sda_q & sda_in;

    // Previous line levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // Byte protocol engine, read byte and write byte only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= HPS_IDLE;
            after_ack <= HPS_IDLE;
            sh <= 8'h00;
            cnt <= 4'h0;
            sda_oe_n <= 1'b1;
            wr_stb <= 1'b0;
            ptr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (!enable || stop_c) begin
                state <= HPS_IDLE;
                sda_oe_n <= 1'b1;
            end else if (start_c) begin
                state <= HPS_ADDR;
                cnt <= 4'h0;
                sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    HPS_ADDR, HPS_CMD, HPS_WDATA: begin
                        if (scl_rise) begin
                            sh <= {sh[6:0], sda_in};
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall && cnt == 4'h8) begin
                            state <= HPS_ACK;
                            sda_oe_n <= 1'b0;
                            if (state == HPS_ADDR) begin
                                // Only own address acked; alert response never matches
                                if (sh[7:1] != dev_addr) begin
                                    state <= HPS_IDLE;
                                    sda_oe_n <= 1'b1;
                                end
                                after_ack <= sh[0] ? HPS_RDATA : HPS_CMD;
                            end else if (state == HPS_CMD) begin
                                ptr <= sh;
                                after_ack <= HPS_WDATA;
                            end else begin
                                wr_data <= sh;
                                wr_stb <= 1'b1;
                                after_ack <= HPS_WDATA;
                            end
                        end
                    end
                    HPS_ACK: begin
                        if (scl_fall) begin
                            state <= after_ack;
                            cnt <= 4'h0;
                            if (after_ack == HPS_RDATA) begin
                                sh <= rd_data;
                                sda_oe_n <= rd_data[7];
                            end else begin
                                sda_oe_n <= 1'b1;
                            end
                        end
                    end
                    HPS_RDATA: begin
                        if (scl_rise) begin
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt == 4'h8) begin
                                state <= HPS_RACK;
                                sda_oe_n <= 1'b1;
                            end else begin
                                sda_oe_n <= sh[3'd7 - cnt[2:0]];
                            end
                        end
                    end
                    HPS_RACK: begin
                        if (scl_rise && sda_in) begin
                            state <= HPS_IDLE;
                        end else if (scl_fall) begin
                            // Master ack: next byte of the same register goes out at once
                            state <= HPS_RDATA;
                            cnt <= 4'h0;
                            sh <= rd_data;
                            sda_oe_n <= rd_data[7];
                        end
                    end
                    default: begin
                        state <= HPS_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: design/hpspc_top.sv */
`timescale 1ns/1ps
module hpspc_top
    import hpspc_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES // Power-on delay in cycles
) (
    input wire logic CLK, // 100 MHz clock
    input wire logic RST_B, // Power-on reset, active low
    input wire logic STBY_UV, // Standby supply under lockout
    input wire logic [1:0] MAIN_UV, // Main supply under lockout or absent, per slot
    input wire logic [1:0] MAIN_EN_PIN, // Main enable pins, per slot
    input wire logic [1:0] AUX_EN_PIN, // Aux enable pins, per slot
    input wire logic [1:0] OVERRIDE_N, // Override inputs, active low
    input wire logic [1:0] MAIN_OC, // Main current over limit
    input wire logic [1:0] MAIN_FAST, // Fast trip comparator
    input wire logic [1:0] AUX_LIM, // Aux in current limit
    input wire logic [1:0] SLOT_HOT, // Slot local overtemperature
    input wire logic DIE_HOT, // Global die overtemperature
    input wire logic [1:0] MAIN_GOOD, // Main outputs delivering power
    input wire logic [1:0] AUX_GOOD, // Aux output delivering power
    input wire logic [1:0] GPI, // General inputs
    input wire logic [2:0] ADDR_STRAP, // Address straps
    input wire logic SCL, // Bus clock level
    input wire logic SDA_IN, // Bus data level
    output logic SDA_O, // Bus data drive level, always low
    output logic SDA_OE_N, // Bus data drive enable, active low
    output logic [1:0] MAIN_ON, // Main gate enables
    output logic [1:0] AUX_ON, // Aux switch enables
    output logic [1:0] FAULT_N_O, // Fault drive level, always low
    output logic [1:0] FAULT_N_OE_N, // Fault pull enable, active low
    output logic [1:0] PGOOD_N_O, // Power good drive level, always low
    output logic [1:0] PGOOD_N_OE_N, // Power good pull enable, active low
    output logic ATTN_N_O, // Attention drive level, always low
    output logic ATTN_N_OE_N // Attention pull enable, active low
);
    logic [POR_W-1:0] por_cnt;
    logic por_done;
    logic [6:0] dev_addr;
    logic [7:0] ctrl [2];
    logic [7:0] stat [2];
    logic [7:0] flags;
    logic [1:0] main_trip;
    logic [1:0] aux_trip;
    logic [1:0] trip_pin;
    logic [1:0] main_req_q;
    logic [1:0] aux_req_q;
    logic [TMR_W-1:0] main_tmr [2];
    logic [TMR_W-1:0] aux_tmr [2];
    logic wr_stb;
    logic [7:0] ptr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic sda_oe_n;
    logic [1:0] ovr;
    logic [1:0] main_req;
    logic [1:0] aux_req;
    logic [1:0] main_exp;
    logic [1:0] aux_exp;
    logic [1:0] hot_kill;
    logic [1:0] set_oc;
    logic [1:0] set_uv;
    logic [1:0] set_aux;
    logic [1:0] next_main_on;
    logic [1:0] next_aux_on;
    logic [1:0] next_pgood;
    logic [1:0] next_fault;
    logic next_attn;

    // True when a write hits the given register
    function automatic logic wr_hit(input logic stb, input logic [7:0] p, input logic [7:0] reg_code);
        wr_hit = stb && (p == reg_code);
    endfunction

    // Echo clear: a hardware set in the same cycle wins
    function automatic logic echo_clr(input logic cur, input logic set, input logic hit, input logic one);
        echo_clr = set | (cur & ~(hit & one));
    endfunction

    // Power-on delay; outputs and bus held off until it expires
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            por_cnt <= '0;
            por_done <= 1'b0;
        end else if (STBY_UV) begin
            por_cnt <= '0;
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 1'b1;
            por_done <= (por_cnt == POR_W'(POR_CNT - 1));
        end
    end

    // Straps caught once at end of power-on delay
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dev_addr <= 7'h00;
        end else if (!por_done && por_cnt == POR_W'(POR_CNT - 1)) begin
            dev_addr <= {BUS_ADDR_HIGH, ADDR_STRAP};
        end
    end

    // Per-slot request and protection terms
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            ovr[s] = ~OVERRIDE_N[s] & ~ctrl[s][CTRL_OVR_BLOCK_BIT];
            main_req[s] = MAIN_EN_PIN[s] | ctrl[s][CTRL_MAIN_BIT];
            aux_req[s] = AUX_EN_PIN[s] | ctrl[s][CTRL_AUX_BIT];
            main_exp[s] = main_tmr[s] == TMR_W'(FAULT_TIMER_CYCLES);
            aux_exp[s] = aux_tmr[s] == TMR_W'(FAULT_TIMER_CYCLES);
            hot_kill[s] = (SLOT_HOT[s] & ~ovr[s]) | DIE_HOT;
            set_oc[s] = por_done & ~ovr[s] & main_req[s] & (MAIN_FAST[s] | main_exp[s]);
            set_uv[s] = por_done & ~ovr[s] & main_req[s] & MAIN_UV[s];
            set_aux[s] = por_done & ~ovr[s] & aux_req[s] & aux_exp[s];
        end
    end

    // Fault timers run while in current limit with the output on
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int s = 0; s < 2; s++) begin
                main_tmr[s] <= '0;
                aux_tmr[s] <= '0;
            end
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (MAIN_OC[s] && MAIN_ON[s] && !ovr[s]) begin
                    if (!main_exp[s]) begin
                        main_tmr[s] <= main_tmr[s] + 1'b1;
                    end
                end else begin
                    main_tmr[s] <= '0;
                end
                if (AUX_LIM[s] && AUX_ON[s] && !ovr[s]) begin
                    if (!aux_exp[s]) begin
                        aux_tmr[s] <= aux_tmr[s] + 1'b1;
                    end
                end else begin
                    aux_tmr[s] <= '0;
                end
            end
        end
    end

    // Trip latches, cleared only by dropping the matching request
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            main_trip <= 2'b00;
            aux_trip <= 2'b00;
            trip_pin <= 2'b00;
            main_req_q <= 2'b00;
            aux_req_q <= 2'b00;
        end else begin
            main_req_q <= main_req;
            aux_req_q <= aux_req;
            for (int s = 0; s < 2; s++) begin
                if (set_oc[s] || set_uv[s] || (hot_kill[s] && por_done)) begin
                    main_trip[s] <= 1'b1;
                end else if (!main_req[s]) begin
                    main_trip[s] <= 1'b0;
                end
                if (set_aux[s] || (hot_kill[s] && por_done)) begin
                    aux_trip[s] <= 1'b1;
                end else if (!aux_req[s]) begin
                    aux_trip[s] <= 1'b0;
                end
                // Fault pin for trips of pin-enabled outputs and for overtemperature trips
                if ((set_oc[s] || set_uv[s]) && MAIN_EN_PIN[s]) begin
                    trip_pin[s] <= 1'b1;
                end else if (set_aux[s] && AUX_EN_PIN[s]) begin
                    trip_pin[s] <= 1'b1;
                end else if (hot_kill[s] && por_done && (main_req[s] || aux_req[s] || SLOT_HOT[s])) begin
                    trip_pin[s] <= 1'b1;
                end else if (!(main_trip[s] || aux_trip[s])) begin
                    trip_pin[s] <= 1'b0;
                end else if ((main_req_q[s] && !main_req[s]) || (aux_req_q[s] && !aux_req[s])) begin
                    trip_pin[s] <= 1'b0;
                end
            end
        end
    end

    // Control registers written by the host
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl[0] <= CTRL_RESET;
            ctrl[1] <= CTRL_RESET;
        end else if (!por_done) begin
            ctrl[0] <= CTRL_RESET;
            ctrl[1] <= CTRL_RESET;
        end else begin
            if (wr_hit(wr_stb, ptr, REG_CTRL_A)) begin
                ctrl[0] <= {5'h00, wr_data[2:0]};
            end
            if (wr_hit(wr_stb, ptr, REG_CTRL_B)) begin
                ctrl[1] <= {5'h00, wr_data[2:0]};
            end
        end
    end

    // Slot status: fault bits sticky, echo-cleared by writing ones; bit 7 follows fault pin
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat[0] <= STAT_RESET;
            stat[1] <= STAT_RESET;
        end else begin
            for (int s = 0; s < 2; s++) begin
                stat[s][STAT_MAIN_OC_BIT] <= echo_clr(stat[s][STAT_MAIN_OC_BIT], set_oc[s],
                    wr_hit(wr_stb, ptr, REG_STAT_A + 8'(s)), wr_data[STAT_MAIN_OC_BIT]);
                stat[s][STAT_MAIN_UV_BIT] <= echo_clr(stat[s][STAT_MAIN_UV_BIT], set_uv[s],
                    wr_hit(wr_stb, ptr, REG_STAT_A + 8'(s)), wr_data[STAT_MAIN_UV_BIT]);
                stat[s][STAT_AUX_BIT] <= echo_clr(stat[s][STAT_AUX_BIT], set_aux[s],
                    wr_hit(wr_stb, ptr, REG_STAT_A + 8'(s)), wr_data[STAT_AUX_BIT]);
                stat[s][STAT_FAULT_PIN_BIT] <= trip_pin[s] & ~ovr[s];
            end
        end
    end

    // Common flags: overheat events, mask, general inputs
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            flags <= FLAGS_RESET;
        end else begin
            flags[FLAGS_SLOT_HOT_BIT] <= echo_clr(flags[FLAGS_SLOT_HOT_BIT],
                por_done & |(SLOT_HOT & ~ovr), wr_hit(wr_stb, ptr, REG_FLAGS), wr_data[FLAGS_SLOT_HOT_BIT]);
            flags[FLAGS_DIE_HOT_BIT] <= echo_clr(flags[FLAGS_DIE_HOT_BIT], por_done & DIE_HOT,
                wr_hit(wr_stb, ptr, REG_FLAGS), wr_data[FLAGS_DIE_HOT_BIT]);
            if (wr_hit(wr_stb, ptr, REG_FLAGS)) begin
                flags[FLAGS_MASK_BIT] <= wr_data[FLAGS_MASK_BIT];
            end
            flags[FLAGS_GPI_A_BIT] <= GPI[0];
            flags[FLAGS_GPI_B_BIT] <= GPI[1];
        end
    end

    // Read mux at the pointer; unknown codes read zero
    always_comb begin
        case (ptr)
            REG_CTRL_A: rd_data = ctrl[0];
            REG_CTRL_B: rd_data = ctrl[1];
            REG_STAT_A: rd_data = stat[0];
            REG_STAT_B: rd_data = stat[1];
            REG_FLAGS: rd_data = flags;
            default: rd_data = 8'h00;
        endcase
    end

    // Next output levels
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            if (STBY_UV || !por_done) begin
                next_main_on[s] = 1'b0;
                next_aux_on[s] = 1'b0;
            end else if (ovr[s]) begin
                next_main_on[s] = ~DIE_HOT;
                next_aux_on[s] = ~DIE_HOT;
            end else begin
                next_main_on[s] = main_req[s] & ~MAIN_UV[s] & ~main_trip[s] & ~set_oc[s]
                    & ~set_uv[s] & ~hot_kill[s];
                next_aux_on[s] = aux_req[s] & ~aux_trip[s] & ~set_aux[s] & ~hot_kill[s];
            end
            next_pgood[s] = ~ovr[s] & main_req[s] & aux_req[s] & MAIN_ON[s] & AUX_ON[s]
                & MAIN_GOOD[s] & AUX_GOOD[s];
            next_fault[s] = ~ovr[s] & trip_pin[s];
        end
        next_attn = ~flags[FLAGS_MASK_BIT] & (stat[0][STAT_MAIN_OC_BIT] | stat[0][STAT_MAIN_UV_BIT]
            | stat[0][STAT_AUX_BIT] | stat[1][STAT_MAIN_OC_BIT] | stat[1][STAT_MAIN_UV_BIT]
            | stat[1][STAT_AUX_BIT] | flags[FLAGS_SLOT_HOT_BIT] | flags[FLAGS_DIE_HOT_BIT]);
    end

    // Registered outputs; open-drain levels fixed low
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            MAIN_ON <= 2'b00;
            AUX_ON <= 2'b00;
            FAULT_N_OE_N <= 2'b11;
            PGOOD_N_OE_N <= 2'b11;
            ATTN_N_OE_N <= 1'b1;
            SDA_OE_N <= 1'b1;
            FAULT_N_O <= 2'b00;
            PGOOD_N_O <= 2'b00;
            ATTN_N_O <= 1'b0;
            SDA_O <= 1'b0;
        end else begin
            MAIN_ON <= next_main_on;
            AUX_ON <= next_aux_on;
            FAULT_N_OE_N <= ~next_fault;
            PGOOD_N_OE_N <= ~next_pgood;
            ATTN_N_OE_N <= ~next_attn;
            SDA_OE_N <= sda_oe_n;
        end
    end

    // Host register port
    hpspc_smbus u_bus (
        .clk(CLK),
        .rst_b(RST_B),
        .enable(por_done),
        .dev_addr(dev_addr),
        .scl(SCL),
        .sda_in(SDA_IN),
        .sda_oe_n(sda_oe_n),
        .wr_stb(wr_stb),
        .ptr(ptr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );
endmodule

/* File: tb/hpspc_chk_sva.sv */
`timescale 1ns/1ps
module hpspc_chk (
    input wire logic CLK, // Clock
    input wire logic RST_B, // Reset
    input wire logic STBY_UV, // Standby low
    input wire logic [1:0] MAIN_UV, // Main low
    input wire logic [1:0] MAIN_FAST, // Fast trip
    input wire logic [1:0] AUX_LIM, // Aux limit
    input wire logic [1:0] SLOT_HOT, // Slot hot
    input wire logic DIE_HOT, // Die hot
    input wire logic [1:0] AUX_EN_PIN, // Aux pins
    input wire logic [1:0] MAIN_GOOD, // Main good
    input wire logic [1:0] AUX_GOOD, // Aux good
    input wire logic [1:0] OVERRIDE_N, // Override
    input wire logic SCL, // Bus clock
    input wire logic SDA_OE_N, // Data pull
    input wire logic [1:0] MAIN_ON, // Main on
    input wire logic [1:0] AUX_ON, // Aux on
    input wire logic [1:0] PGOOD_N_OE_N // Power good
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Trips and lockouts shut outputs within two clocks; then fast trip sparing aux, power good cause, data drive timing
    chk_fast_main_off: assert property (MAIN_FAST[0] && OVERRIDE_N[0] |-> ##[1:2] !MAIN_ON[0])
        else $error("fast trip kept main on");
    chk_slot_hot_off: assert property (SLOT_HOT[0] && OVERRIDE_N[0] |-> ##[1:2] !(MAIN_ON[0] | AUX_ON[0]))
        else $error("slot hot kept output on");
    chk_die_hot_off: assert property (DIE_HOT |-> ##[1:2] (MAIN_ON == 2'h0) && (AUX_ON == 2'h0))
        else $error("die hot kept output on");
    chk_standby_all_off: assert property (STBY_UV |-> ##[1:2] (MAIN_ON == 2'h0) && (AUX_ON == 2'h0))
        else $error("standby lockout kept output on");
    chk_main_uv_off: assert property (MAIN_UV[0] && OVERRIDE_N[0] |-> ##[1:2] !MAIN_ON[0])
        else $error("main lockout kept main on");
    chk_aux_no_fast: assert property (MAIN_FAST[0] && AUX_ON[0] && AUX_EN_PIN[0] && !AUX_LIM[0]
        && !SLOT_HOT[0] && !DIE_HOT && !STBY_UV |=> AUX_ON[0]) else $error("fast trip hit aux");
    chk_pgood_cause: assert property (!PGOOD_N_OE_N[0] |-> $past(MAIN_GOOD[0] & AUX_GOOD[0]))
        else $error("power good without power");
    chk_sda_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL)
        else $error("data drive changed with clock high");
    // Main scenarios
    cover property ($fell(MAIN_ON[0]));
    cover property (!OVERRIDE_N[1] && AUX_ON[1]);
    cover property (!SDA_OE_N);
endmodule
bind hpspc_top hpspc_chk u_hpspc_chk (.*);

/* File: tb/hpspc_host.sv */
`timescale 1ns/1ps
module hpspc_host (
    input wire logic clk, // Clock
    input wire logic sda_oe_n, // Device pulls data
    output logic scl, // Bus clock
    output logic sda // Data line
);
    logic drv = 1'h1;
    int nack = 0;
    // Pulled-up line, either side pulls low
    assign sda = drv & sda_oe_n;
    initial scl = 1'h1;
    // One bit: clock low five clocks, then high four clocks
    task automatic bit_io(input logic b, output logic s);
        #1 drv = b;
        repeat (4) @(posedge clk);
        #1 scl = 1'h1;
        repeat (4) @(posedge clk);
        s = sda;
        #1 scl = 1'h0;
        @(posedge clk);
    endtask
    // Start or repeated start, then n bits of f; acks checked at and above lo
    task automatic frame(input logic [26:0] f, input int n, input int lo, output logic [7:0] d);
        logic s;
        #1 drv = 1'h1;
        repeat (4) @(posedge clk);
        #1 scl = 1'h1;
        repeat (4) @(posedge clk);
        #1 drv = 1'h0;
        repeat (4) @(posedge clk);
        #1 scl = 1'h0;
        for (int i = n - 1; i >= 0; i--) begin
            bit_io(f[i], s);
            if (i > 0) d = {d[6:0], s};
            if (i % 9 == 0 && i >= lo && s !== 1'h0) nack++;
        end
    endtask
    // Stop: data low under low clock, released while clock high
    task automatic bus_stop;
        #1 drv = 1'h0;
        repeat (4) @(posedge clk);
        #1 scl = 1'h1;
        repeat (4) @(posedge clk);
        #1 drv = 1'h1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Write byte: address, command, data, stop
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
        logic [7:0] q;
        frame({a, 1'h0, 1'h1, c, 1'h1, d, 1'h1}, 27, 0, q);
        bus_stop;
    endtask
    // Read byte: address and command, repeated start, address, data, master nack, stop
    task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d);
        frame({9'h0, a, 1'h0, 1'h1, c, 1'h1}, 18, 0, d);
        frame({9'h0, a, 1'h1, 1'h1, 8'hFF, 1'h1}, 18, 9, d);
        bus_stop;
    endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    import hpspc_pkg::*;
    logic CLK = 1'h0;
    logic RST_B = 1'h0;
    logic STBY_UV = 1'h0;
    logic DIE_HOT = 1'h0;
    logic [1:0] MAIN_UV = 2'h0, MAIN_EN_PIN = 2'h0, AUX_EN_PIN = 2'h0, OVERRIDE_N = 2'h3, MAIN_FAST = 2'h0;
    logic [1:0] MAIN_OC = 2'h0, AUX_LIM = 2'h0, SLOT_HOT = 2'h0, GPI = 2'h2;
    logic [2:0] ADDR_STRAP = 3'h5;
    logic SCL, SDA_IN, SDA_OE_N, ATTN_N_OE_N;
    logic [1:0] MAIN_ON, AUX_ON, FAULT_N_OE_N, PGOOD_N_OE_N;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] rdv;
    // Loads report good once switched on
    wire [1:0] MAIN_GOOD = MAIN_ON;
    wire [1:0] AUX_GOOD = AUX_ON;
    wire [7:0] outs = {MAIN_ON, AUX_ON, FAULT_N_OE_N, PGOOD_N_OE_N};
    hpspc_top #(.POR_CNT(20)) u_hpspc_top (.*, .SDA_O(), .FAULT_N_O(), .PGOOD_N_O(), .ATTN_N_O());
    hpspc_host u_hpspc_host (.clk(CLK), .sda_oe_n(SDA_OE_N), .scl(SCL), .sda(SDA_IN));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #5 CLK = ~CLK;
    // Hang guard
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 8000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial begin
        step(8);
        RST_B = 1'h1;
        step(1);
        chk("reset outs", 8'h0F, outs);
        step(40);
        {MAIN_EN_PIN, AUX_EN_PIN} = 4'h5;
        step(5);
        chk("pin on", 8'h5E, outs);
        MAIN_FAST = 2'h1;
        step(1);
        MAIN_FAST = 2'h0;
        step(4);
        chk("fast trip", 8'h1B, outs);
        chk("attn trip", 8'h00, {7'h0, ATTN_N_OE_N});
        u_hpspc_host.rd({BUS_ADDR_HIGH, ADDR_STRAP}, REG_STAT_A, rdv);
        chk("stat a", 8'h81, rdv);
        MAIN_EN_PIN = 2'h0;
        step(3);
        MAIN_EN_PIN = 2'h1;
        step(5);
        chk("restart", 8'h5E, outs);
        u_hpspc_host.wr(7'h0C, REG_STAT_A, 8'h01);
        chk("attn held", 8'h00, {7'h0, ATTN_N_OE_N});
        u_hpspc_host.wr({BUS_ADDR_HIGH, ADDR_STRAP}, REG_STAT_A, 8'h01);
        step(4);
        chk("attn clear", 8'h01, {7'h0, ATTN_N_OE_N});
        chk("nacks", 8'h03, 8'(u_hpspc_host.nack));
        OVERRIDE_N = 2'h1;
        step(5);
        chk("override", 8'hFE, outs);
        u_hpspc_host.wr({BUS_ADDR_HIGH, ADDR_STRAP}, REG_CTRL_B, 8'h04);
        step(4);
        chk("blocked", 8'h5E, outs);
        u_hpspc_host.wr({BUS_ADDR_HIGH, ADDR_STRAP}, REG_CTRL_B, 8'h07);
        MAIN_OC = 2'h2;
        step(1990);
        chk("slow hold", 8'hFC, outs);
        step(20);
        chk("slow trip", 8'h7E, outs);
        MAIN_OC = 2'h0;
        u_hpspc_host.wr({BUS_ADDR_HIGH, ADDR_STRAP}, REG_CTRL_B, 8'h05);
        u_hpspc_host.wr({BUS_ADDR_HIGH, ADDR_STRAP}, REG_CTRL_B, 8'h07);
        step(4);
        chk("bit restart", 8'hFC, outs);
        u_hpspc_host.wr({BUS_ADDR_HIGH, ADDR_STRAP}, REG_FLAGS, 8'h08);
        MAIN_UV = 2'h1;
        step(5);
        chk("main uv", 8'hB9, outs);
        chk("attn mask", 8'h01, {7'h0, ATTN_N_OE_N});
        DIE_HOT = 1'h1;
        step(4);
        chk("die hot", 8'h00, {4'h0, outs[7:4]});
        u_hpspc_host.rd({BUS_ADDR_HIGH, ADDR_STRAP}, REG_FLAGS, rdv);
        chk("flags", 8'h2C, rdv);
        SLOT_HOT = 2'h1;
        STBY_UV = 1'h1;
        step(4);
        report_and_stop;
    end
endmodule
